// ### shared/npr_pkg.sv
package npr_pkg;

  // ----------------------------------------
  // command codes on the data lines
  // ----------------------------------------
  localparam logic [7:0] CMD_MAIN = 8'h00;
  localparam logic [7:0] CMD_MAIN_HI = 8'h01;
  localparam logic [7:0] CMD_SPARE = 8'h50;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] ADDR_ID = 8'h00;

  // ----------------------------------------
  // page geometry, in columns
  // ----------------------------------------
  localparam logic [9:0] COLS_X8 = 10'h210;
  localparam logic [9:0] COLS_X16 = 10'h108;
  localparam logic [9:0] HALF_X8 = 10'h100;
  localparam logic [9:0] SPARE_X8 = 10'h010;
  localparam logic [9:0] SPARE_X16 = 10'h008;
  localparam logic [9:0] ID_READS = 10'h002;
  localparam logic [4:0] BLOCK_LAST_PAGE = 5'h1F;
  localparam logic [1:0] ADDR_STEPS = 2'h3;
  localparam logic [1:0] ADDR_STEPS_ID = 2'h1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PAGE_LOAD_TIME_NS = 10000;
  localparam int BUSY_SETTLE_NS = 200;
  localparam logic [7:0] PAGE_LOAD_CYC = 8'(PAGE_LOAD_TIME_NS / CLK_PERIOD_NS);
  localparam logic [7:0] BUSY_SETTLE_CYC =
    8'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_MAIN = 2'b00,
    OP_MAIN_HI = 2'b01,
    OP_SPARE = 2'b10,
    OP_ID = 2'b11
  } npr_op_e;

  typedef enum logic [1:0] {
    AREA_MAIN = 2'b00,
    AREA_HALF = 2'b01,
    AREA_SPARE = 2'b10
  } npr_area_e;

  typedef struct packed {
    npr_op_e op;
    logic wide;
    logic seq;
    logic [15:0] row;
    logic [7:0] col;
  } npr_req_s;

  typedef struct packed {
    logic ceN;
    logic cle;
    logic ale;
    logic weN;
    logic reN;
    logic ioOe;
    logic [15:0] ioOut;
  } npr_pins_s;

  localparam npr_pins_s PINS_IDLE = '{ceN: 1'b1, cle: 1'b0, ale: 1'b0, weN: 1'b1,
                                      reN: 1'b1, ioOe: 1'b0, ioOut: 16'h0000};

endpackage

// ### verilog/npr_host.sv
`timescale 1ns/1ns
`default_nettype none
module npr_host
  import npr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // request side
  input wire logic reqValid,
  output logic reqReady,
  input wire npr_req_s reqIn,
  output logic reqDone,
  output logic pageTimeout,
  output npr_area_e areaPtr,
  // read data side
  output logic [15:0] rdData,
  output logic rdValid,
  output logic rdLast,
  input wire logic rdReady,
  // flash pins
  output npr_pins_s pins,
  input wire logic [15:0] ioIn,
  input wire logic rbReady
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] cmdCode(input npr_op_e op);
    case (op)
      OP_MAIN: cmdCode = CMD_MAIN;
      OP_MAIN_HI: cmdCode = CMD_MAIN_HI;
      OP_SPARE: cmdCode = CMD_SPARE;
      default: cmdCode = CMD_ID;
    endcase
  endfunction

  // words from start column to last column, spare select held low
  function automatic logic [9:0] wordCount(input npr_op_e op, input logic wide,
                                           input logic [7:0] col);
    case (op)
      OP_MAIN: wordCount = (wide ? COLS_X16 : COLS_X8) - {2'b00, col};
      OP_MAIN_HI: wordCount = COLS_X8 - HALF_X8 - {2'b00, col};
      OP_SPARE: wordCount = wide ? SPARE_X16 - {7'h00, col[2:0]} :
                                   SPARE_X8 - {6'h00, col[3:0]};
      default: wordCount = ID_READS;
    endcase
  endfunction

  function automatic logic [7:0] addrByte(input logic [1:0] step, input npr_req_s r);
    if (r.op == OP_ID) begin
      addrByte = ADDR_ID;
    end else if (step == 2'h1) begin
      if (r.op == OP_SPARE) begin
        addrByte = r.wide ? {5'h00, r.col[2:0]} : {4'h0, r.col[3:0]};
      end else begin
        addrByte = r.col;
      end
    end else if (step == 2'h2) begin
      addrByte = r.row[7:0];
    end else begin
      addrByte = r.row[15:8];
    end
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_WLO = 4'b0001,
    S_WHI = 4'b0010,
    S_BUSYW = 4'b0011,
    S_READYW = 4'b0100,
    S_RLO = 4'b0101,
    S_RHI = 4'b0110,
    S_END = 4'b0111
  } npr_state_e;

  npr_state_e state, next_state;
  logic [1:0] step, next_step;
  logic [9:0] cnt, next_cnt;
  logic [7:0] timer, next_timer;
  npr_req_s req, next_req;
  npr_pins_s next_pins;
  logic [15:0] next_rdData;
  logic next_rdValid, next_rdLast, next_done, next_timeout;
  npr_area_e next_ptr;
  logic [1:0] lastStep;
  logic seqGo;

  assign reqReady = (state == S_IDLE);
  assign lastStep = (req.op == OP_ID) ? ADDR_STEPS_ID : ADDR_STEPS;
  assign seqGo = req.seq && (req.op != OP_ID) && (req.row[4:0] != BLOCK_LAST_PAGE);

  always_comb begin
    next_state = state;
    next_step = step;
    next_cnt = cnt;
    next_timer = timer;
    next_req = req;
    next_pins = pins;
    next_rdData = rdData;
    next_rdValid = rdValid & ~rdReady;
    next_rdLast = rdLast;
    next_ptr = areaPtr;
    next_done = 1'b0;
    next_timeout = pageTimeout;
    case (state)
      S_IDLE: begin
        next_pins = PINS_IDLE;
        if (reqValid) begin
          next_req = reqIn;
          next_step = 2'h0;
          next_timeout = 1'b0;
          next_cnt = wordCount(reqIn.op, reqIn.wide, reqIn.col);
          next_pins.ceN = 1'b0;
          next_pins.cle = 1'b1;
          next_pins.weN = 1'b0;
          next_pins.ioOe = 1'b1;
          // every page read request sends its pointer command, so the area is always known
          next_pins.ioOut = {8'h00, cmdCode(reqIn.op)};
          next_state = S_WLO;
        end
      end
      S_WLO: begin
        next_pins.weN = 1'b1;
        next_state = S_WHI;
      end
      S_WHI: begin
        if (step == lastStep) begin
          next_pins.cle = 1'b0;
          next_pins.ale = 1'b0;
          next_pins.ioOe = 1'b0;
          next_pins.ioOut = 16'h0000;
          if (req.op == OP_ID) begin
            next_pins.reN = 1'b0;
            next_state = S_RLO;
          end else begin
            next_timer = BUSY_SETTLE_CYC;
            next_state = S_BUSYW;
          end
        end else begin
          next_step = step + 2'h1;
          next_pins.cle = 1'b0;
          next_pins.ale = 1'b1;
          next_pins.weN = 1'b0;
          next_pins.ioOut = {8'h00, addrByte(step + 2'h1, req)};
          next_state = S_WLO;
        end
      end
      S_BUSYW: begin
        if (timer <= 8'h01) begin
          next_timer = 8'h00;
          next_state = S_READYW;
        end else begin
          next_timer = timer - 8'h01;
        end
      end
      S_READYW: begin
        if (rbReady) begin
          next_pins.ceN = 1'b0;
          next_pins.reN = 1'b0;
          next_state = S_RLO;
        end else if (timer == PAGE_LOAD_CYC) begin
          next_timeout = 1'b1;
          next_state = S_END;
        end else begin
          next_timer = timer + 8'h01;
        end
      end
      S_RLO: begin
        next_pins.reN = 1'b1;
        next_rdData = ioIn;
        next_rdValid = 1'b1;
        next_rdLast = (cnt == 10'h001) && !seqGo;
        next_state = S_RHI;
      end
      S_RHI: begin
        if (rdReady) begin
          if (cnt == 10'h001) begin
            if (seqGo) begin
              // device selects the next page itself; host only tracks the row
              next_req.row = req.row + 16'h0001;
              next_cnt = wordCount(req.op, req.wide, 8'h00);
              next_timer = BUSY_SETTLE_CYC;
              next_state = S_BUSYW;
            end else begin
              next_state = S_END;
            end
          end else begin
            next_cnt = cnt - 10'h001;
            next_pins.ceN = 1'b0;
            next_pins.reN = 1'b0;
            next_state = S_RLO;
          end
        end else if (!req.seq) begin
          // save power while the consumer stalls; would abort a sequential read
          next_pins.ceN = 1'b1;
        end
      end
      S_END: begin
        next_pins = PINS_IDLE;
        next_done = 1'b1;
        if (req.op == OP_SPARE) begin
          next_ptr = AREA_SPARE;
        end else if (req.op != OP_ID) begin
          next_ptr = AREA_MAIN;
        end
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= S_IDLE;
      step <= 2'h0;
      cnt <= 10'h000;
      timer <= 8'h00;
      req <= '0;
      pins <= PINS_IDLE;
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      rdLast <= 1'b0;
      areaPtr <= AREA_MAIN;
      reqDone <= 1'b0;
      pageTimeout <= 1'b0;
    end else begin
      state <= next_state;
      step <= next_step;
      cnt <= next_cnt;
      timer <= next_timer;
      req <= next_req;
      pins <= next_pins;
      rdData <= next_rdData;
      rdValid <= next_rdValid;
      rdLast <= next_rdLast;
      areaPtr <= next_ptr;
      reqDone <= next_done;
      pageTimeout <= next_timeout;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [1:0] addrSeen;
  logic [9:0] pageReads;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state == S_IDLE) begin
      addrSeen <= 2'h0;
      pageReads <= 10'h000;
    end else begin
      if (state == S_WLO && pins.ale) addrSeen <= addrSeen + 2'h1;
      if (state == S_BUSYW && $past(state) == S_RHI) pageReads <= 10'h000;
      else if (state == S_RLO) pageReads <= pageReads + 10'h001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_upper_lines_zero: assert property (pins.ioOe |-> pins.ioOut[15:8] == 8'h00)
    else $error("upper data lines driven in command or address cycle");
  a_three_addr: assert property (
    (state == S_WHI && next_state == S_BUSYW) |-> addrSeen == 2'h3)
    else $error("page read started without three address cycles");
  a_no_read_busy: assert property (
    $fell(pins.reN) && req.op != OP_ID |-> $past(rbReady) || $past(state) == S_RHI)
    else $error("read strobe issued while device busy");
  a_spare_x16_col: assert property (
    pins.ale && !pins.weN && step == 2'h1 && req.op == OP_SPARE && req.wide
    |-> pins.ioOut[7:3] == 5'h00)
    else $error("spare start column has high bits set");
  a_seq_ce_low: assert property (state == S_RHI && req.seq |=> !pins.ceN)
    else $error("chip select rose inside sequential read");
  a_ce_release: assert property (
    state == S_RHI && !rdReady && !req.seq |=> pins.ceN)
    else $error("chip select not released while stalled");
  a_block_stop: assert property (
    state == S_BUSYW && $past(state) == S_RHI |-> req.row[4:0] != 5'h00)
    else $error("sequential read crossed a block boundary");
  a_page_len: assert property (state == S_END |-> pageReads <= COLS_X8)
    else $error("page read longer than one page");
  a_id_two: assert property (
    state == S_END && req.op == OP_ID && !pageTimeout |-> pageReads == 10'h002)
    else $error("identity read not two cycles");
  a_main_cmd: assert property (
    pins.cle && pins.ioOe && req.op == OP_MAIN |-> pins.ioOut[7:0] == CMD_MAIN)
    else $error("main read without main pointer command");
  a_half_return: assert property (
    state == S_END && req.op == OP_MAIN_HI |=> areaPtr == AREA_MAIN)
    else $error("second half pointer did not return");

  c_main_read: cover property (state == S_END && req.op == OP_MAIN);
  c_seq_next: cover property (state == S_BUSYW && $past(state) == S_RHI);
  c_stall_ce: cover property (state == S_RHI && pins.ceN);
  c_id_read: cover property (state == S_END && req.op == OP_ID);

endmodule
`default_nettype wire

// ### verif/npr_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module npr_flash_model
  import npr_pkg::*;
#(
  parameter int LOAD_NS = 3000,
  parameter logic [7:0] MAKER = 8'h3C, // arbitrary value
  parameter logic [7:0] DEVICE = 8'hA6 // arbitrary value
) (
  // host pins
  input wire npr_pins_s pins,
  input wire logic wide,
  // device answers
  output logic [15:0] ioIn,
  output logic rbReady,
  output logic [7:0] badCnt
);
  npr_area_e area = AREA_MAIN;
  logic idMode = 1'b0;
  logic [1:0] addrCnt = 2'h0;
  logic [15:0] row = 16'h0000;
  logic [9:0] col = 10'h000;
  logic [15:0] dout = 16'h0000;
  logic [7:0] a;
  realtime readyAt = 0;
  wire drive;

  function automatic logic [15:0] pat(input logic [15:0] r, input logic [9:0] c);
    return {r[7:0] ^ c[7:0], c[7:0] ^ {c[9:8], r[5:0]}};
  endfunction

  initial badCnt = 8'h00;
  // released lines show the inverse, so a stale sample cannot pass
  assign #15 drive = !pins.ceN && !pins.reN;
  assign ioIn = drive ? dout : ~dout;
  // updates sit between clock edges, so the host never races the busy flag
  initial begin
    rbReady = 1'b1;
    #5;
    forever begin
      rbReady = ($realtime >= readyAt);
      #10;
    end
  end

  always @(posedge pins.weN) begin
    a = pins.ioOut[7:0];
    if ((pins.cle || pins.ale) && pins.ioOut[15:8] !== 8'h00) badCnt = badCnt + 8'h01;
    if (pins.cle) begin
      addrCnt = 2'h0;
      idMode = (a == CMD_ID);
      if (a == CMD_MAIN) area = AREA_MAIN;
      if (a == CMD_MAIN_HI) area = AREA_HALF;
      if (a == CMD_SPARE) area = AREA_SPARE;
    end else if (pins.ale) begin
      if (addrCnt == 2'h0) begin
        if (idMode) col = 10'h000;
        else if (area == AREA_SPARE) begin
          col = wide ? 10'h100 + 10'(a[2:0]) : 10'h200 + 10'(a[3:0]);
        end else col = (area == AREA_HALF ? 10'h100 : 10'h000) + 10'(a);
      end
      if (addrCnt == 2'h1) row[7:0] = a;
      if (addrCnt == 2'h2) begin
        row[15:8] = a;
        readyAt = $realtime + LOAD_NS;
        if (area == AREA_HALF) area = AREA_MAIN;
      end
      addrCnt = addrCnt + 2'h1;
    end
  end

  always @(negedge pins.reN) begin
    if (rbReady !== 1'b1) badCnt = badCnt + 8'h01;
    if (idMode) begin
      dout = {8'h00, col == 10'h000 ? MAKER : DEVICE};
      col = col + 10'h001;
    end else begin
      dout = pat(row, col);
      if (col == (wide ? 10'h107 : 10'h20F)) begin
        row = row + 16'h0001;
        col = area == AREA_SPARE ? (wide ? 10'h100 : 10'h200) : 10'h000;
        readyAt = $realtime + LOAD_NS;
      end else col = col + 10'h001;
    end
  end
  // row and column stay put, so reading resumes once chip select returns
  always @(posedge pins.ceN) readyAt = 0;
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import npr_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] DEVICE = 8'hA6; // arbitrary value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  logic rdReady = 1'b0;
  npr_req_s reqIn = '0;
  logic reqReady, reqDone, pageTimeout, rdValid, rdLast, rbReady;
  logic [15:0] rdData, ioIn;
  logic [7:0] badCnt;
  npr_area_e areaPtr;
  npr_pins_s pins;
  int error_cnt = 0;
  int total_checks = 0;

  npr_host uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .reqIn(reqIn), .reqDone(reqDone), .pageTimeout(pageTimeout), .areaPtr(areaPtr),
    .rdData(rdData), .rdValid(rdValid), .rdLast(rdLast), .rdReady(rdReady),
    .pins(pins), .ioIn(ioIn), .rbReady(rbReady)
  );
  npr_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) flash (
    .pins(pins), .wide(reqIn.wide), .ioIn(ioIn), .rbReady(rbReady), .badCnt(badCnt)
  );

  // --------
  // helpers
  // --------
  function automatic logic [15:0] expWord(input logic [15:0] r, input logic [9:0] c);
    return {r[7:0] ^ c[7:0], c[7:0] ^ {c[9:8], r[5:0]}};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one request; words expected from column fc, n per page, over pg pages
  task automatic xfer(input npr_req_s rq, input int fc, input int n, input int pg,
                      input int stall, input npr_area_e area);
    int i;
    int w;
    logic [15:0] exp;
    logic [15:0] msk;
    msk = rq.wide ? 16'hFFFF : 16'h00FF;
    @(posedge clk_sys);
    #10 reqValid = 1'b1;
    reqIn = rq;
    chk(16'(reqReady), 16'h0001);
    @(posedge clk_sys);
    #10 reqValid = 1'b0;
    rdReady = (stall == 0);
    chk(16'(reqReady), 16'h0000);
    for (i = 0; i < n * pg; i++) begin
      // look just after the edge, once the registered word has settled
      w = 0;
      do begin
        @(posedge clk_sys);
        #1 w++;
      end while (rdValid !== 1'b1 && w < 400);
      if (rq.op == OP_ID) exp = (i == 0) ? 16'(MAKER) : 16'(DEVICE);
      else exp = expWord(rq.row + 16'(i / n), 10'(fc + i % n));
      chk(rdData & msk, exp & msk);
      chk(16'(rdLast), 16'(i == n * pg - 1));
      if (stall > 0) begin
        repeat (stall) @(posedge clk_sys);
        #10 rdReady = 1'b1;
        chk(rdData & msk, exp & msk);
        @(posedge clk_sys);
        #10 rdReady = 1'b0;
      end
    end
    if (stall == 0) begin
      @(posedge clk_sys);
      #10 rdReady = 1'b0;
    end
    w = 0;
    do begin
      @(posedge clk_sys);
      #1 w++;
    end while (reqDone !== 1'b1 && w < 20);
    chk(16'(reqDone), 16'h0001);
    chk(16'(areaPtr), 16'(area));
    chk(16'(pageTimeout), 16'h0000);
  endtask

  // --------
  // scenarios
  // --------
  task automatic t_main_x8;
    chk(16'(areaPtr), 16'(AREA_MAIN));
    xfer('{OP_MAIN, 1'b0, 1'b0, 16'h0005, 8'h00}, 0, 528, 1, 0, AREA_MAIN);
  endtask

  task automatic t_x16;
    xfer('{OP_SPARE, 1'b1, 1'b0, 16'h0123, 8'h03}, 259, 5, 1, 0, AREA_SPARE);
    xfer('{OP_MAIN, 1'b1, 1'b0, 16'h0124, 8'hFA}, 250, 14, 1, 0, AREA_MAIN);
  endtask

  task automatic t_half;
    xfer('{OP_MAIN_HI, 1'b0, 1'b0, 16'h0200, 8'h04}, 260, 268, 1, 0, AREA_MAIN);
  endtask

  task automatic t_stall;
    xfer('{OP_SPARE, 1'b0, 1'b0, 16'h0301, 8'h1A}, 522, 6, 1, 12, AREA_SPARE);
  endtask

  task automatic t_seq;
    xfer('{OP_SPARE, 1'b0, 1'b1, 16'h003E, 8'h00}, 512, 16, 2, 3, AREA_SPARE);
  endtask

  task automatic t_id;
    xfer('{OP_ID, 1'b0, 1'b0, 16'h0000, 8'h00}, 0, 2, 1, 0, AREA_SPARE);
  endtask

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // whole run is near 2300 cycles; ten times that means a hang
  initial begin
    #(2_500_000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #10 rst_n = 1'b1;
    t_main_x8();
    t_x16();
    t_half();
    t_stall();
    t_seq();
    t_id();
    chk(16'(badCnt), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
